// >>> verilog/tdc_regs.v
// Contract
// [RQ1] Data watch bits 23:16 enable per thread
// [RQ2] Four data watch controls at 0x70..0x73
// [RQ3] Bit 2 lets data watch fire on loads
// [RQ4] Bit 1: zero A and B, one A or B
// [RQ5] Bit 0 master enable gates every interrupt
// [RQ6] Four 32-bit resource watch mask registers
// [RQ7] Four 32-bit resource watch value registers
// [RQ8] Four resource controls, thread bits, master enable
// [RQ9] Resource bit 1 picks condition A or B
// [RQ10] Access only by numbered configuration transactions
// [RQ11] Identity returns processor, node, revision, version
// [RQ12] Counts A: channel ends, locks, synchronisers
// [RQ13] Counts B: clock blocks and timers
// [RQ14] Permission bit 31 refuses all remote writes (here only writes to 0x05, 0x06, scratch and processor status)
// [RQ15] Permission bit 0 refuses system switch writes (here only writes to 0x05, 0x06, scratch and processor status)
// [RQ16] Writing request bit raises debug interrupt
// [RQ17] Request bit 1 reads debug mode
// [RQ18] Eight core program counters read-only
// [RQ19] Eight core status words read-only
// [RQ20] Record cause four data, five resource
// [RQ21] Data watch uses first and second addresses
// [RQ22] Fire needs enable, thread bit, condition
// [RQ23] Reserved bits read zero, ignore writes
`include "tdc_defs.vh"
`default_nettype none

module tdc_regs #(
  parameter [7:0] PROC_ID   = 8'h00, // Arbitrary value
  parameter [7:0] NODE_ID   = 8'h00, // Arbitrary value
  parameter [7:0] REVISION  = 8'h00, // Arbitrary value
  parameter [7:0] VERSION   = 8'h00, // Arbitrary value
  parameter [7:0] NUM_CHAN  = 8'h20,
  parameter [7:0] NUM_LOCK  = 8'h04,
  parameter [7:0] NUM_SYNC  = 8'h07,
  parameter [7:0] NUM_CLKB  = 8'h06,
  parameter [7:0] NUM_TIMER = 8'h0A
) (
  // Clock and reset
  input  wire         CLK,
  input  wire         SRST,
  // Configuration transaction
  input  wire         CFG_REQ,
  input  wire         CFG_WR,
  input  wire         CFG_SPACE,
  input  wire [7:0]   CFG_NUM,
  input  wire [1:0]   CFG_SRC,
  input  wire [31:0]  CFG_WDATA,
  output reg          CFG_ACK,
  output reg  [31:0]  CFG_RDATA,
  output reg          CFG_ERR,
  // Core state readback
  input  wire [255:0] CORE_PC,
  input  wire [255:0] CORE_SW,
  input  wire         DEBUG_MODE,
  input  wire [31:0]  SECURITY_IN,
  // Memory operation stream
  input  wire         MEM_VALID,
  input  wire         MEM_LOAD,
  input  wire [2:0]   MEM_THREAD,
  input  wire [31:0]  MEM_ADDR,
  // Resource operation stream
  input  wire         RES_VALID,
  input  wire [2:0]   RES_THREAD,
  input  wire [31:0]  RES_ID,
  // Debug interrupt outputs
  output reg          HOST_DBG_REQ,
  output reg          WATCH_IRQ,
  output reg  [31:0]  IRQ_TYPE,
  output reg  [31:0]  IRQ_DATA,
  output reg  [31:0]  CLK_DIVIDE
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [31:0] dw_ctrl_r   [0:3];
  reg  [31:0] dw_addr1_r  [0:3];
  reg  [31:0] dw_addr2_r  [0:3];
  reg  [31:0] rw_mask_r   [0:3];
  reg  [31:0] rw_value_r  [0:3];
  reg  [31:0] rw_ctrl_r   [0:3];
  reg  [31:0] scratch_r   [0:7];
  reg  [31:0] perm_r;
  reg  [31:0] rd_nxt;
  reg         hit_nxt;
  reg         refused;
  reg         dbg_wr;
  reg         dw_any;
  reg         rw_any;
  reg  [1:0]  dw_num;
  reg  [1:0]  rw_num;
  wire [3:0]  dw_fire;
  wire [3:0]  rw_fire;
  wire        wr_req;
  wire [1:0]  idx4;
  wire [2:0]  idx8;
  integer     i;
  integer     j;

  assign wr_req = CFG_REQ & CFG_WR;
  assign idx4   = CFG_NUM[1:0];
  assign idx8   = CFG_NUM[2:0];

  // ----------------------------------------------------------------
  // Watchpoint comparators
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_watch
      wire cond_a;
      wire cond_b;
      wire res_a;
      wire res_b;
      wire dw_cond;
      wire rw_cond;
      // Range window: A is at or above the first address, B at or below the second
      assign cond_a  = (MEM_ADDR >= dw_addr1_r[g]); // RQ21
      assign cond_b  = (MEM_ADDR <= dw_addr2_r[g]); // RQ21
      assign dw_cond = dw_ctrl_r[g][`TDC_CTRL_SEL] ? (cond_a | cond_b)
                                                    : (cond_a & cond_b); // RQ4
      // Stores always qualify, loads only when asked for
      assign dw_fire[g] = MEM_VALID & dw_ctrl_r[g][`TDC_CTRL_EN]            // RQ5
                        & dw_ctrl_r[g][`TDC_CTRL_THR_LO + MEM_THREAD]      // RQ1
                        & (~MEM_LOAD | dw_ctrl_r[g][`TDC_CTRL_LOADS])       // RQ3
                        & dw_cond;                                          // RQ22
      // A matches the masked identifier, B is its mismatch
      assign res_a   = ((RES_ID & rw_mask_r[g]) == rw_value_r[g]); // RQ6 RQ7
      assign res_b   = ~res_a;
      assign rw_cond = rw_ctrl_r[g][`TDC_CTRL_SEL] ? res_b : res_a; // RQ9
      assign rw_fire[g] = RES_VALID & rw_ctrl_r[g][`TDC_CTRL_EN]          // RQ8
                        & rw_ctrl_r[g][`TDC_CTRL_THR_LO + RES_THREAD]    // RQ8
                        & rw_cond;                                        // RQ22
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lowest numbered watchpoint of each kind wins; a data hit beats a resource hit in the same cycle
  // ----------------------------------------------------------------
  always @* begin
    dw_any = |dw_fire;
    rw_any = |rw_fire;
    dw_num = 2'h0;
    rw_num = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (dw_fire[i]) begin
        dw_num = i[1:0];
      end
      if (rw_fire[i]) begin
        rw_num = i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write permission check
  // ----------------------------------------------------------------
  // Local core accesses are never restricted, so the debug ROM keeps control
  always @* begin
    dbg_wr  = 1'b1;
    refused = 1'b0;
    if (CFG_SPACE == `TDC_SPACE_TILE) begin
      dbg_wr = (CFG_NUM == `TDC_REG_DBG_REQUEST) || (CFG_NUM == `TDC_REG_CLK_DIVIDE)
             || (CFG_NUM[7:3] == `TDC_REG_SCRATCH >> 3);
    end
    if (perm_r[`TDC_PERM_ALL] && (CFG_SRC != `TDC_SRC_LOCAL)) begin
      refused = dbg_wr; // RQ14
    end
    if (perm_r[`TDC_PERM_SYS] && (CFG_SRC == `TDC_SRC_SYSTEM)) begin
      refused = dbg_wr; // RQ15
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer and address decode
  // ----------------------------------------------------------------
  always @* begin
    rd_nxt  = 32'h00000000;
    hit_nxt = 1'b1;
    if (CFG_SPACE == `TDC_SPACE_TILE) begin
      if (CFG_NUM == `TDC_REG_IDENTITY) begin
        rd_nxt = {PROC_ID, NODE_ID, REVISION, VERSION}; // RQ11
      end else if (CFG_NUM == `TDC_REG_COUNTS_A) begin
        rd_nxt = {NUM_CHAN, NUM_LOCK, NUM_SYNC, 8'h00}; // RQ12
      end else if (CFG_NUM == `TDC_REG_COUNTS_B) begin
        rd_nxt = {16'h0000, NUM_CLKB, NUM_TIMER}; // RQ13
      end else if (CFG_NUM == `TDC_REG_PERMISSION) begin
        rd_nxt = perm_r;
      end else if (CFG_NUM == `TDC_REG_DBG_REQUEST) begin
        rd_nxt = {30'h00000000, DEBUG_MODE, 1'b0}; // RQ17
      end else if (CFG_NUM == `TDC_REG_CLK_DIVIDE) begin
        rd_nxt = CLK_DIVIDE;
      end else if (CFG_NUM == `TDC_REG_SECURITY) begin
        rd_nxt = SECURITY_IN;
      end else if (CFG_NUM[7:3] == `TDC_REG_SCRATCH >> 3) begin
        rd_nxt = scratch_r[idx8];
      end else if (CFG_NUM[7:3] == `TDC_REG_CORE_PC >> 3) begin
        rd_nxt = CORE_PC[idx8*32 +: 32]; // RQ18
      end else if (CFG_NUM[7:3] == `TDC_REG_CORE_SW >> 3) begin
        rd_nxt = CORE_SW[idx8*32 +: 32]; // RQ19
      end else begin
        hit_nxt = 1'b0;
      end
    end else begin
      if (CFG_NUM[7:2] == `TDC_REG_DW_ADDR1 >> 2) begin
        rd_nxt = dw_addr1_r[idx4];
      end else if (CFG_NUM[7:2] == `TDC_REG_DW_ADDR2 >> 2) begin
        rd_nxt = dw_addr2_r[idx4];
      end else if (CFG_NUM[7:2] == `TDC_REG_DW_CTRL >> 2) begin
        rd_nxt = dw_ctrl_r[idx4]; // RQ2
      end else if (CFG_NUM[7:2] == `TDC_REG_RW_MASK >> 2) begin
        rd_nxt = rw_mask_r[idx4];
      end else if (CFG_NUM[7:2] == `TDC_REG_RW_VALUE >> 2) begin
        rd_nxt = rw_value_r[idx4];
      end else if (CFG_NUM[7:2] == `TDC_REG_RW_CTRL >> 2) begin
        rd_nxt = rw_ctrl_r[idx4];
      end else if (CFG_NUM == `TDC_REG_IRQ_TYPE) begin
        rd_nxt = IRQ_TYPE;
      end else if (CFG_NUM == `TDC_REG_IRQ_DATA) begin
        rd_nxt = IRQ_DATA;
      end else begin
        hit_nxt = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transaction answer, one cycle after the request
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      CFG_ACK   <= 1'b0;
      CFG_RDATA <= 32'h00000000;
      CFG_ERR   <= 1'b0;
    end else begin
      CFG_ACK   <= CFG_REQ; // RQ10
      CFG_RDATA <= (CFG_REQ && !CFG_WR) ? rd_nxt : 32'h00000000;
      CFG_ERR   <= CFG_REQ & (~hit_nxt | (CFG_WR & refused));
    end
  end

  // ----------------------------------------------------------------
  // Register writes; reserved bits are masked off on the way in
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      perm_r       <= `TDC_RESET_VALUE;
      CLK_DIVIDE   <= `TDC_RESET_VALUE;
      HOST_DBG_REQ <= 1'b0;
      // Own loop variable, so the priority pick above stays the only driver of i
      for (j = 0; j < 4; j = j + 1) begin
        dw_ctrl_r[j]  <= `TDC_RESET_VALUE;
        dw_addr1_r[j] <= `TDC_RESET_VALUE;
        dw_addr2_r[j] <= `TDC_RESET_VALUE;
        rw_mask_r[j]  <= `TDC_RESET_VALUE;
        rw_value_r[j] <= `TDC_RESET_VALUE;
        rw_ctrl_r[j]  <= `TDC_RESET_VALUE;
      end
      for (j = 0; j < 8; j = j + 1) begin
        scratch_r[j] <= `TDC_RESET_VALUE;
      end
    end else begin
      HOST_DBG_REQ <= 1'b0;
      if (wr_req && hit_nxt && !refused) begin // RQ10
        if (CFG_SPACE == `TDC_SPACE_TILE) begin
          if (CFG_NUM == `TDC_REG_PERMISSION) begin
            perm_r <= CFG_WDATA & `TDC_PERM_MASK; // RQ23
          end else if (CFG_NUM == `TDC_REG_DBG_REQUEST) begin
            HOST_DBG_REQ <= CFG_WDATA[`TDC_DBGREQ_REQ]; // RQ16
          end else if (CFG_NUM == `TDC_REG_CLK_DIVIDE) begin
            CLK_DIVIDE <= CFG_WDATA & `TDC_CLKDIV_MASK; // RQ23
          end else if (CFG_NUM[7:3] == `TDC_REG_SCRATCH >> 3) begin
            scratch_r[idx8] <= CFG_WDATA;
          end
        end else begin
          if (CFG_NUM[7:2] == `TDC_REG_DW_ADDR1 >> 2) begin
            dw_addr1_r[idx4] <= CFG_WDATA; // RQ21
          end else if (CFG_NUM[7:2] == `TDC_REG_DW_ADDR2 >> 2) begin
            dw_addr2_r[idx4] <= CFG_WDATA; // RQ21
          end else if (CFG_NUM[7:2] == `TDC_REG_DW_CTRL >> 2) begin
            dw_ctrl_r[idx4] <= CFG_WDATA & `TDC_CTRL_MASK; // RQ2 RQ23
          end else if (CFG_NUM[7:2] == `TDC_REG_RW_MASK >> 2) begin
            rw_mask_r[idx4] <= CFG_WDATA; // RQ6
          end else if (CFG_NUM[7:2] == `TDC_REG_RW_VALUE >> 2) begin
            rw_value_r[idx4] <= CFG_WDATA; // RQ7
          end else if (CFG_NUM[7:2] == `TDC_REG_RW_CTRL >> 2) begin
            rw_ctrl_r[idx4] <= CFG_WDATA & `TDC_RCTRL_MASK; // RQ8 RQ23
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Debug interrupt cause capture
  // ----------------------------------------------------------------
  // A watchpoint hit beats a software write of the cause in the same cycle,
  // so a trigger is never lost behind a debugger update
  always @(posedge CLK) begin
    if (SRST) begin
      WATCH_IRQ <= 1'b0;
      IRQ_TYPE  <= `TDC_RESET_VALUE;
      IRQ_DATA  <= `TDC_RESET_VALUE;
    end else begin
      WATCH_IRQ <= dw_any | rw_any; // RQ22
      if (dw_any) begin
        IRQ_TYPE <= {14'h0000, dw_num, 5'h00, MEM_THREAD, 5'h00, `TDC_CAUSE_DATA}; // RQ20
        IRQ_DATA <= MEM_ADDR;
      end else if (rw_any) begin
        IRQ_TYPE <= {14'h0000, rw_num, 5'h00, RES_THREAD, 5'h00, `TDC_CAUSE_RES}; // RQ20
        IRQ_DATA <= RES_ID;
      end else if (wr_req && !refused && (CFG_SPACE == `TDC_SPACE_PSTAT)) begin
        if (CFG_NUM == `TDC_REG_IRQ_TYPE) begin
          IRQ_TYPE <= CFG_WDATA & `TDC_IRQ_TYPE_MASK; // RQ23
        end else if (CFG_NUM == `TDC_REG_IRQ_DATA) begin
          IRQ_DATA <= CFG_WDATA;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> verilog/tdc_defs.vh
`ifndef TDC_DEFS_VH
`define TDC_DEFS_VH

// ----------------------------------------------------------------
// Address spaces of a configuration access
// ----------------------------------------------------------------
`define TDC_SPACE_TILE      1'b0
`define TDC_SPACE_PSTAT     1'b1

// ----------------------------------------------------------------
// Tile configuration register numbers
// ----------------------------------------------------------------
`define TDC_REG_IDENTITY    8'h00
`define TDC_REG_COUNTS_A    8'h01
`define TDC_REG_COUNTS_B    8'h02
`define TDC_REG_PERMISSION  8'h04
`define TDC_REG_DBG_REQUEST 8'h05
`define TDC_REG_CLK_DIVIDE  8'h06
`define TDC_REG_SECURITY    8'h07
`define TDC_REG_SCRATCH     8'h20
`define TDC_REG_CORE_PC     8'h40
`define TDC_REG_CORE_SW     8'h60

// ----------------------------------------------------------------
// Processor status register numbers (watchpoint set)
// ----------------------------------------------------------------
`define TDC_REG_DW_ADDR1    8'h50
`define TDC_REG_DW_ADDR2    8'h60
`define TDC_REG_DW_CTRL     8'h70
`define TDC_REG_RW_MASK     8'h80
`define TDC_REG_RW_VALUE    8'h90
`define TDC_REG_RW_CTRL     8'h9C
`define TDC_REG_IRQ_TYPE    8'h15
`define TDC_REG_IRQ_DATA    8'h16

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define TDC_CTRL_MASK       32'h00FF0007
`define TDC_RCTRL_MASK      32'h00FF0003
`define TDC_CTRL_EN         0
`define TDC_CTRL_SEL        1
`define TDC_CTRL_LOADS      2
`define TDC_CTRL_THR_LO     16
`define TDC_PERM_ALL        31
`define TDC_PERM_SYS        0
`define TDC_PERM_MASK       32'h80000001
`define TDC_DBGREQ_REQ      0
`define TDC_DBGREQ_MODE     1
`define TDC_CLKDIV_MASK     32'h8000FFFF
`define TDC_IRQ_TYPE_MASK   32'h0003FF07
`define TDC_RESET_VALUE     32'h00000000

// ----------------------------------------------------------------
// Access sources and debug interrupt causes
// ----------------------------------------------------------------
`define TDC_SRC_SYSTEM      2'h0
`define TDC_SRC_SCRATCH     2'h1
`define TDC_SRC_JTAG        2'h2
`define TDC_SRC_LOCAL       2'h3
`define TDC_CAUSE_DATA      3'h4
`define TDC_CAUSE_RES       3'h5

`endif

// >>> verif/tdc_regs_monitor.sv
`default_nettype none
module tdc_regs_monitor #(
  parameter [7:0] PROC_ID  = 8'h00,
  parameter [7:0] NODE_ID  = 8'h00,
  parameter [7:0] REVISION = 8'h00,
  parameter [7:0] VERSION  = 8'h00,
  parameter [7:0] NUM_CHAN = 8'h00,
  parameter [7:0] NUM_LOCK = 8'h00,
  parameter [7:0] NUM_SYNC = 8'h00
) (
  // Clock and reset
  input wire logic         CLK,
  input wire logic         SRST,
  // Configuration transaction
  input wire logic         CFG_REQ,
  input wire logic         CFG_WR,
  input wire logic         CFG_SPACE,
  input wire logic [7:0]   CFG_NUM,
  input wire logic [1:0]   CFG_SRC,
  input wire logic [31:0]  CFG_WDATA,
  input wire logic         CFG_ACK,
  input wire logic [31:0]  CFG_RDATA,
  // Core state and watch streams
  input wire logic [255:0] CORE_PC,
  input wire logic [255:0] CORE_SW,
  input wire logic         DEBUG_MODE,
  input wire logic         MEM_VALID,
  input wire logic [31:0]  MEM_ADDR,
  input wire logic         RES_VALID,
  input wire logic [31:0]  RES_ID,
  // Debug interrupt outputs
  input wire logic         HOST_DBG_REQ,
  input wire logic         WATCH_IRQ,
  input wire logic [31:0]  IRQ_TYPE,
  input wire logic [31:0]  IRQ_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Selected core words, picked by the low number bits
  // ------------------------------------------------------------
  logic [31:0] pc_sel;
  logic [31:0] sw_sel;
  assign pc_sel = CORE_PC[{CFG_NUM[2:0], 5'h00} +: 32];
  assign sw_sel = CORE_SW[{CFG_NUM[2:0], 5'h00} +: 32];

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  // Tile space read of one number, or of a group of eight
  sequence rd_tile(logic [7:0] n);
    CFG_REQ && !CFG_WR && !CFG_SPACE && CFG_NUM == n;
  endsequence
  sequence rd_core(logic [4:0] g);
    CFG_REQ && !CFG_WR && !CFG_SPACE && CFG_NUM[7:3] == g;
  endsequence
  // Local core never restricted, so this write always lands
  sequence wr_dbg;
    CFG_REQ && CFG_WR && !CFG_SPACE && CFG_NUM == 8'h05 && CFG_SRC == 2'h3 && CFG_WDATA[0];
  endsequence

  ack_follows_req_a: assert property (CFG_REQ |=> CFG_ACK)
    else $error("no acknowledge after request");
  ack_needs_req_a: assert property (CFG_ACK |-> $past(CFG_REQ))
    else $error("acknowledge without request");
  ident_read_a: assert property (rd_tile(8'h00) |=>
    CFG_RDATA == {PROC_ID, NODE_ID, REVISION, VERSION}) else $error("identity wrong");
  counts_read_a: assert property (rd_tile(8'h01) |=>
    CFG_RDATA == {NUM_CHAN, NUM_LOCK, NUM_SYNC, 8'h00}) else $error("counts wrong");
  mode_read_a: assert property (rd_tile(8'h05) |=> CFG_RDATA[1] == $past(DEBUG_MODE))
    else $error("debug mode bit wrong");
  dbg_request_a: assert property (wr_dbg |=> HOST_DBG_REQ)
    else $error("debug request not raised");
  core_pc_read_a: assert property (rd_core(5'h08) |=> CFG_RDATA == $past(pc_sel))
    else $error("core counter readback wrong");
  core_sw_read_a: assert property (rd_core(5'h0C) |=> CFG_RDATA == $past(sw_sel))
    else $error("core status readback wrong");
  irq_cause_a: assert property (WATCH_IRQ |-> $past(MEM_VALID || RES_VALID) &&
    IRQ_TYPE[2:0] inside {3'h4, 3'h5}) else $error("watch interrupt cause wrong");
  irq_data_a: assert property (WATCH_IRQ |-> IRQ_DATA ==
    (IRQ_TYPE[2:0] == 3'h4 ? $past(MEM_ADDR) : $past(RES_ID))) else $error("watch data wrong");
endmodule

bind tdc_regs tdc_regs_monitor #(.PROC_ID(PROC_ID), .NODE_ID(NODE_ID), .REVISION(REVISION),
  .VERSION(VERSION), .NUM_CHAN(NUM_CHAN), .NUM_LOCK(NUM_LOCK), .NUM_SYNC(NUM_SYNC))
  tdc_regs_monitor_i (.CLK(CLK), .SRST(SRST), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR),
  .CFG_SPACE(CFG_SPACE), .CFG_NUM(CFG_NUM), .CFG_SRC(CFG_SRC), .CFG_WDATA(CFG_WDATA),
  .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA), .CORE_PC(CORE_PC), .CORE_SW(CORE_SW),
  .DEBUG_MODE(DEBUG_MODE), .MEM_VALID(MEM_VALID), .MEM_ADDR(MEM_ADDR),
  .RES_VALID(RES_VALID), .RES_ID(RES_ID), .HOST_DBG_REQ(HOST_DBG_REQ),
  .WATCH_IRQ(WATCH_IRQ), .IRQ_TYPE(IRQ_TYPE), .IRQ_DATA(IRQ_DATA));
`default_nettype wire

// >>> verif/tdc_core_model.sv
`default_nettype none
module tdc_core_model (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Request from the register bank
  input  wire logic         host_dbg_req,
  // Core state seen by the bank
  output logic [255:0]      core_pc,
  output logic [255:0]      core_sw,
  output logic              debug_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Fixed per-core words so every slot is distinguishable
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      core_pc[c*32 +: 32] = 32'h10000000 + c;
      core_sw[c*32 +: 32] = 32'h00000B00 + c;
    end
  end
  // Processor enters debug mode one cycle after the request; stays until reset
  always @(posedge clk) begin
    if (srst) debug_mode <= 1'b0;
    else if (host_dbg_req) debug_mode <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> verif/tdc_regs_bench.sv
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tdc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, req, wr, sp, dmode, mv, ml, rv, ack, err, hreq, wirq;
  logic [7:0] num;
  logic [1:0] src;
  logic [2:0] mth, rth;
  logic [31:0] wd, rd, ma, rid, ityp, idat, cdiv, sec;
  logic [255:0] pc, sw;
  int n_mismatch = 0;
  int comparisons = 0;

  // Counts keep their defaults; only the identity fields are overridden
  tdc_regs #(.PROC_ID(8'h12), .NODE_ID(8'h34), .REVISION(8'h56), .VERSION(8'h78))
    tdc_regs_i (.CLK(clk), .SRST(srst), .CFG_REQ(req), .CFG_WR(wr),
    .CFG_SPACE(sp), .CFG_NUM(num), .CFG_SRC(src), .CFG_WDATA(wd), .CFG_ACK(ack),
    .CFG_RDATA(rd), .CFG_ERR(err), .CORE_PC(pc), .CORE_SW(sw), .DEBUG_MODE(dmode),
    .SECURITY_IN(sec), .MEM_VALID(mv), .MEM_LOAD(ml), .MEM_THREAD(mth),
    .MEM_ADDR(ma), .RES_VALID(rv), .RES_THREAD(rth), .RES_ID(rid), .HOST_DBG_REQ(hreq),
    .WATCH_IRQ(wirq), .IRQ_TYPE(ityp), .IRQ_DATA(idat), .CLK_DIVIDE(cdiv));
  tdc_core_model tdc_core_model_i (.clk(clk), .srst(srst), .host_dbg_req(hreq),
    .core_pc(pc), .core_sw(sw), .debug_mode(dmode));

  // ------------------------------------------------------------
  // Clock, verdict and bus tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One transaction; the answer stands only in the cycle after the request
  task automatic cfg(input logic w, s, input logic [7:0] n, input logic [1:0] o,
                     input logic [31:0] d, ex, input logic er);
    @(negedge clk);
    {req, wr, sp, num, src, wd} = {1'b1, w, s, n, o, d};
    @(negedge clk);
    req = 1'b0;
    `CHK(ack, 1'b1)
    `CHK(rd, ex)
    `CHK(err, er)
  endtask
  task automatic wrd(input logic s, input logic [7:0] n, input logic [31:0] d, ex);
    cfg(1'b1, s, n, 2'h3, d, 32'h0, 1'b0);
    cfg(1'b0, s, n, 2'h3, 32'h0, ex, 1'b0);
  endtask
  // One memory or resource operation, then the interrupt it should cause
  task automatic wt(input logic l, r, input logic [2:0] t, input logic [31:0] a,
                    input logic f, input logic [31:0] ty);
    @(negedge clk);
    {mv, rv, ml, mth, rth, ma, rid} = {!r, r, l, t, t, a, a};
    @(negedge clk);
    {mv, rv} = 2'b00;
    `CHK(wirq, f)
    if (f) begin
      `CHK(ityp, ty)
      `CHK(idat, a)
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {srst, req, wr, sp, num, src, wd, mv, ml, mth, ma, rv, rth, rid} = '0;
    srst = 1'b1;
    sec = 32'h00005A00;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    // Reset values, identity, counts, unmapped and read-only places
    cfg(0, 0, 8'h04, 3, 0, 32'h0, 0);
    cfg(0, 0, 8'h05, 3, 0, 32'h0, 0);
    cfg(0, 1, 8'h70, 3, 0, 32'h0, 0);
    cfg(0, 1, 8'h9F, 3, 0, 32'h0, 0);
    cfg(0, 0, 8'h00, 3, 0, 32'h12345678, 0);
    cfg(0, 0, 8'h01, 3, 0, 32'h20040700, 0);
    cfg(0, 0, 8'h02, 3, 0, 32'h0000060A, 0);
    cfg(0, 0, 8'h07, 3, 0, 32'h00005A00, 0);
    cfg(1, 0, 8'h00, 3, 32'hFFFFFFFF, 32'h0, 0);
    cfg(0, 0, 8'h03, 3, 0, 32'h0, 1);
    wrd(0, 8'h06, 32'hFFFFFFFF, 32'h8000FFFF);
    `CHK(cdiv, 32'h8000FFFF)
    for (int c = 0; c < 8; c++) begin
      cfg(0, 0, 8'h40 + c[7:0], 3, 0, 32'h10000000 + c, 0);
      cfg(0, 0, 8'h60 + c[7:0], 3, 0, 32'h00000B00 + c, 0);
      cfg(1, 0, 8'h40 + c[7:0], 3, 32'h0, 32'h0, 0);
    end
    // Write permission: all remote sources, then system switch only
    wrd(0, 8'h04, 32'hFFFFFFFF, 32'h80000001);
    cfg(1, 0, 8'h20, 0, 32'hAA, 32'h0, 1);
    cfg(1, 0, 8'h20, 2, 32'hAA, 32'h0, 1);
    cfg(1, 1, 8'h70, 1, 32'h1, 32'h0, 1);
    cfg(1, 0, 8'h04, 3, 32'h1, 32'h0, 0);
    cfg(1, 0, 8'h20, 0, 32'hBB, 32'h0, 1);
    cfg(1, 0, 8'h20, 2, 32'hCC, 32'h0, 0);
    cfg(0, 0, 8'h20, 3, 0, 32'hCC, 0);
    cfg(1, 0, 8'h04, 3, 32'h0, 32'h0, 0);
    // Debug request makes the processor enter debug mode
    cfg(1, 0, 8'h05, 3, 32'h1, 32'h0, 0);
    cfg(0, 0, 8'h05, 3, 0, 32'h2, 0);
    // Data watchpoint 0 over 0x100..0x1FF for thread 2
    wrd(1, 8'h50, 32'h100, 32'h100);
    wrd(1, 8'h60, 32'h1FF, 32'h1FF);
    wrd(1, 8'h73, 32'hFFFFFFFE, 32'h00FF0006);
    wrd(1, 8'h70, 32'h00040001, 32'h00040001);
    wt(0, 0, 2, 32'h150, 1, 32'h00000204);
    wt(0, 0, 3, 32'h150, 0, 0);
    wt(1, 0, 2, 32'h150, 0, 0);
    wt(0, 0, 2, 32'h300, 0, 0);
    wrd(1, 8'h70, 32'h00040007, 32'h00040007);
    wt(1, 0, 2, 32'h300, 1, 32'h00000204);
    wrd(1, 8'h70, 32'h00040006, 32'h00040006);
    wt(0, 0, 2, 32'h150, 0, 0);
    // Resource watchpoint 1 on low byte 0x42 for thread 0
    wrd(1, 8'h81, 32'hFFFFFFFF, 32'hFFFFFFFF);
    wrd(1, 8'h81, 32'h000000FF, 32'h000000FF);
    wrd(1, 8'h91, 32'hFFFFFFFF, 32'hFFFFFFFF);
    wrd(1, 8'h91, 32'h00000042, 32'h00000042);
    wrd(1, 8'h9D, 32'hFFFFFFFF, 32'h00FF0003);
    wrd(1, 8'h9D, 32'h00010001, 32'h00010001);
    wt(0, 1, 0, 32'h1242, 1, 32'h00010005);
    wt(0, 1, 1, 32'h1242, 0, 0);
    wrd(1, 8'h9D, 32'h00010003, 32'h00010003);
    wt(0, 1, 0, 32'h1242, 0, 0);
    wt(0, 1, 0, 32'h1243, 1, 32'h00010005);
    wrd(1, 8'h9D, 32'h00010002, 32'h00010002);
    wt(0, 1, 0, 32'h1243, 0, 0);
    report_and_stop();
  end
  // Hang guard: a run this long is counted as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
